//--- buffer_counter.v
// Up/down counter of posted buffers waiting for use.
module buffer_counter #(
	parameter CNT_W = 6
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire up,
	input wire down,
	output reg [CNT_W-1:0] count_ff
);

	wire full;
	wire empty;

	assign full = &count_ff;
	assign empty = ~|count_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= {CNT_W{1'b0}};
		end else if (ce) begin
			if (up && !full && !(down && !empty)) begin
				count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
			end else if (down && !empty && !(up && !full)) begin
				count_ff <= count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

//--- driver_model.sv
// Guest driver model that posts event buffers and accepts returned records.
module driver_model (
	input wire aclk,
	input wire post_req,
	input wire [15:0] post_len,
	input wire stall,
	output logic buf_post,
	output logic [15:0] buf_len,
	output logic rec_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		buf_post = 1'h0;
		buf_len = 16'h0010;
		rec_ready = 1'h1;
	end
	// Posts one buffer per request and holds its length until the next post.
	always @(posedge aclk) begin
		buf_post <= post_req;
		if (post_req) begin
			buf_len <= post_len;
		end
	end
	// A stalled driver accepts record words only on every other cycle.
	always @(posedge aclk) begin
		rec_ready <= !stall || !rec_ready;
	end
endmodule

//--- event_reporter.v
// Event queue reporter: formats logical-unit event records into posted buffers.
// Operation
// - No buffer: discard event, except paced bursts.
// - Bursts over many units may be held back.
// - Bit 31 marks earlier lost events.
// - Short buffer returns at once, no-event code.
// - After drops, new buffer may prompt no-event.
// - Reset record: code 1, lun, reason.
// - Reasons: reset 0, appeared 1, gone 2.
// - Unit 0 gone/appeared may mean target.
// - Hot-plug reasons only with negotiated feature.
// - Each reset reason also exposed as sense.
// - Async record: code 2, subscribed reasons only.
`include "event_reporter_defines.vh"

module event_reporter #(
	parameter ADDR_W = 8,
	parameter CNT_W = 6
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [ADDR_W-1:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [ADDR_W-1:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire buf_post,
	input wire [15:0] buf_len,
	input wire evt_valid,
	output reg evt_ready,
	input wire evt_kind,
	input wire evt_burst,
	input wire [63:0] evt_lun,
	input wire [31:0] evt_reason,
	output reg rec_valid,
	input wire rec_ready,
	output reg [31:0] rec_data,
	output wire rec_last,
	output reg [7:0] rec_len,
	output reg [3:0] sense_key,
	output reg [7:0] sense_asc,
	output reg [7:0] sense_ascq,
	output wire irq
);

	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	reg [2:0] ctrl_ff;
	reg [15:0] evt_size_ff;
	reg [31:0] subscribe_ff;
	reg [`IRQ_W-1:0] irq_stat_ff;
	reg [`IRQ_W-1:0] irq_mask_ff;
	reg [31:0] drop_cnt_ff;
	reg missed_ff;
	reg state_ff;
	reg [1:0] idx_ff;
	reg [1:0] last_idx_ff;
	reg [95:0] shift_ff;
	reg aw_held_ff;
	reg w_held_ff;
	reg [ADDR_W-1:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg buf_post_q1_ff;
	reg buf_post_q2_ff;
	reg [15:0] buf_len_q1_ff;
	reg [15:0] buf_len_q2_ff;

	wire [CNT_W-1:0] good_cnt;
	wire [CNT_W-1:0] short_cnt;
	wire buf_short;
	wire have_buf;
	wire hot_plug_feature;
	wire reason_hot_plug;
	wire [31:0] async_reason;
	wire suppress;
	wire do_write;
	wire rec_done;

	reg take_short;
	reg take_prompt;
	reg take_event;
	reg take_drop;
	reg take_discard;
	reg use_good;
	reg [31:0] nxt_code;
	reg [31:0] nxt_wreg;
	reg [31:0] nxt_rdata;
	reg [1:0] nxt_rresp;

	////////////////////////////////////////////////////////////////////////////
	// Buffer posting arrives from outside and is synchronised first.
	always @(posedge aclk) begin
		if (!aresetn) begin
			buf_post_q1_ff <= 1'b0;
			buf_post_q2_ff <= 1'b0;
			buf_len_q1_ff <= 16'h0000;
			buf_len_q2_ff <= 16'h0000;
		end else if (ce) begin
			buf_post_q1_ff <= buf_post;
			buf_post_q2_ff <= buf_post_q1_ff;
			buf_len_q1_ff <= buf_len;
			buf_len_q2_ff <= buf_len_q1_ff;
		end
	end

	assign buf_short = buf_len_q2_ff < evt_size_ff;

	buffer_counter #(.CNT_W(CNT_W)) good_bufs (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.up(buf_post_q2_ff && !buf_short),
		.down(use_good),
		.count_ff(good_cnt)
	);

	buffer_counter #(.CNT_W(CNT_W)) short_bufs (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.up(buf_post_q2_ff && buf_short),
		.down(take_short),
		.count_ff(short_cnt)
	);

	////////////////////////////////////////////////////////////////////////////
	// Event admission and record selection.
	assign have_buf = |good_cnt;
	assign hot_plug_feature = ctrl_ff[`CTRL_HOT_PLUG_FEATURE];
	assign reason_hot_plug = (evt_reason == `REASON_UNIT_APPEARED) ||
		(evt_reason == `REASON_UNIT_GONE);
	assign async_reason = evt_reason & subscribe_ff;
	assign suppress = (evt_kind == `KIND_RESET) ? (reason_hot_plug && !hot_plug_feature)
		: ~|async_reason;

	always @* begin
		take_short = 1'b0;
		take_prompt = 1'b0;
		take_event = 1'b0;
		take_drop = 1'b0;
		take_discard = 1'b0;
		evt_ready = 1'b0;
		// A frozen block takes no event, so nothing is lost while the clock enable is low.
		if (ce && state_ff == ST_IDLE) begin
			if (|short_cnt) begin
				take_short = 1'b1;
			end else if (evt_valid) begin
				if (suppress) begin
					evt_ready = 1'b1;
					take_discard = 1'b1;
				end else if (have_buf) begin
					evt_ready = 1'b1;
					take_event = 1'b1;
				end else if (!(evt_burst && ctrl_ff[`CTRL_THROTTLE_EN])) begin
					evt_ready = 1'b1;
					take_drop = 1'b1;
				end
			end else if (missed_ff && have_buf && ctrl_ff[`CTRL_PROMPT_EN]) begin
				take_prompt = 1'b1;
			end
		end
		use_good = take_event || take_prompt;
		nxt_code = (evt_kind == `KIND_RESET) ? `CODE_TRANSPORT_RESET
			: `ASYNC_NOTICE_CODE;
		if (take_short || take_prompt) begin
			nxt_code = `CODE_NO_EVENT;
		end
		nxt_code[`LOST_NOTICES_BIT] = missed_ff;
	end

	////////////////////////////////////////////////////////////////////////////
	// Record output stream.
	assign rec_done = rec_valid && rec_ready && rec_last;
	assign rec_last = idx_ff == last_idx_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			idx_ff <= 2'h0;
			last_idx_ff <= `WORDS_SHORT;
			shift_ff <= 96'h0;
			rec_valid <= 1'b0;
			rec_data <= 32'h00000000;
			rec_len <= 8'h00;
			missed_ff <= 1'b0;
			drop_cnt_ff <= 32'h00000000;
		end else if (ce) begin
			case (state_ff)
				ST_IDLE: begin
					if (take_short || take_prompt || take_event) begin
						state_ff <= ST_SEND;
						rec_valid <= 1'b1;
						rec_data <= nxt_code;
						idx_ff <= 2'h0;
						missed_ff <= 1'b0;
						// Unit 0 is passed unchanged so it can name a whole target.
						shift_ff <= {async_reason | (evt_kind == `KIND_RESET ? evt_reason : 32'h0),
							evt_lun};
						if (take_event) begin
							last_idx_ff <= `WORDS_FULL;
							rec_len <= `LEN_FULL_RECORD;
						end else begin
							last_idx_ff <= `WORDS_SHORT;
							rec_len <= `LEN_SHORT_RECORD;
						end
					end
					if (take_drop) begin
						missed_ff <= 1'b1;
						drop_cnt_ff <= drop_cnt_ff + 32'h00000001;
					end
				end
				ST_SEND: begin
					if (rec_valid && rec_ready) begin
						if (rec_last) begin
							rec_valid <= 1'b0;
							state_ff <= ST_IDLE;
						end else begin
							rec_data <= shift_ff[31:0];
							shift_ff <= {32'h0, shift_ff[95:32]};
							idx_ff <= idx_ff + 2'h1;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					rec_valid <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sense data for the last reported transport reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			sense_key <= 4'h0;
			sense_asc <= 8'h00;
			sense_ascq <= 8'h00;
		end else if (ce && take_event && evt_kind == `KIND_RESET) begin
			if (evt_reason == `REASON_UNIT_GONE) begin
				sense_key <= `SENSE_ILLEGAL_REQUEST;
				sense_asc <= `ASC_UNIT_GONE;
				sense_ascq <= `ASCQ_UNIT_GONE;
			end else if (evt_reason == `REASON_UNIT_APPEARED) begin
				sense_key <= `SENSE_UNIT_ATTENTION;
				sense_asc <= `ASC_UNIT_APPEARED;
				sense_ascq <= `ASCQ_UNIT_APPEARED;
			end else if (evt_reason == `REASON_UNIT_RESET) begin
				sense_key <= `SENSE_UNIT_ATTENTION;
				sense_asc <= `ASC_UNIT_RESET;
				sense_ascq <= `ASCQ_UNIT_RESET;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus write channel: address and data are taken in either order.
	assign awready = ce && !aw_held_ff && !bvalid;
	assign wready = ce && !w_held_ff && !bvalid;
	assign do_write = aw_held_ff && w_held_ff && !bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= {ADDR_W{1'b0}};
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid <= 1'b1;
				case (awaddr_ff)
					`REG_CTRL, `REG_EVT_SIZE, `REG_SUBSCRIBE, `REG_IRQ_STATUS,
					`REG_IRQ_MASK: bresp <= `RESP_OKAY;
					default: bresp <= `RESP_SLVERR;
				endcase
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always @* begin
		nxt_wreg = 32'h00000000;
		case (awaddr_ff)
			`REG_CTRL: nxt_wreg = {29'h0, ctrl_ff};
			`REG_EVT_SIZE: nxt_wreg = {16'h0, evt_size_ff};
			`REG_SUBSCRIBE: nxt_wreg = subscribe_ff;
			`REG_IRQ_MASK: nxt_wreg = {29'h0, irq_mask_ff};
			default: nxt_wreg = 32'h00000000;
		endcase
		if (wstrb_ff[0]) nxt_wreg[7:0] = wdata_ff[7:0];
		if (wstrb_ff[1]) nxt_wreg[15:8] = wdata_ff[15:8];
		if (wstrb_ff[2]) nxt_wreg[23:16] = wdata_ff[23:16];
		if (wstrb_ff[3]) nxt_wreg[31:24] = wdata_ff[31:24];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= `CTRL_RESET;
			evt_size_ff <= `EVT_SIZE_RESET;
			subscribe_ff <= `SUBSCRIBE_RESET;
			irq_mask_ff <= {`IRQ_W{1'b0}};
		end else if (ce && do_write) begin
			case (awaddr_ff)
				`REG_CTRL: ctrl_ff <= nxt_wreg[2:0];
				`REG_EVT_SIZE: evt_size_ff <= nxt_wreg[15:0];
				`REG_SUBSCRIBE: subscribe_ff <= nxt_wreg;
				`REG_IRQ_MASK: irq_mask_ff <= nxt_wreg[`IRQ_W-1:0];
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status: set wins over a write-one clear.
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= {`IRQ_W{1'b0}};
		end else if (ce) begin
			irq_stat_ff <= (irq_stat_ff & ~((do_write && awaddr_ff == `REG_IRQ_STATUS && wstrb_ff[0])
				? wdata_ff[`IRQ_W-1:0] : {`IRQ_W{1'b0}}))
				| {take_short, rec_done, take_drop};
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	////////////////////////////////////////////////////////////////////////////
	// Bus read channel.
	assign arready = ce && !rvalid;

	always @* begin
		nxt_rresp = `RESP_OKAY;
		case (araddr)
			`REG_CTRL: nxt_rdata = {29'h0, ctrl_ff};
			`REG_EVT_SIZE: nxt_rdata = {16'h0, evt_size_ff};
			`REG_SUBSCRIBE: nxt_rdata = subscribe_ff;
			`REG_STATE: nxt_rdata = {8'h0, {(8-CNT_W){1'b0}}, short_cnt,
				{(8-CNT_W){1'b0}}, good_cnt, 6'h0, state_ff, missed_ff};
			`REG_IRQ_STATUS: nxt_rdata = {29'h0, irq_stat_ff};
			`REG_IRQ_MASK: nxt_rdata = {29'h0, irq_mask_ff};
			`REG_SENSE: nxt_rdata = {12'h0, sense_key, sense_asc, sense_ascq};
			`REG_DROP_COUNT: nxt_rdata = drop_cnt_ff;
			default: begin
				nxt_rdata = 32'h00000000;
				nxt_rresp = `RESP_SLVERR;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= nxt_rdata;
				rresp <= nxt_rresp;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

endmodule

//--- event_reporter_bench.sv
// Self-checking bench for the event queue reporter.
`include "event_reporter_defines.vh"
module event_reporter_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic evt_valid = 0, evt_kind = 0, evt_burst = 0, post_req = 0, stall = 0, t;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, evt_reason = 0;
	logic [63:0] evt_lun = 64'h0123456789abcdef;
	logic [15:0] post_len = 16'h0010;
	wire awready, wready, bvalid, arready, rvalid, evt_ready, rec_valid, rec_ready, rec_last;
	wire irq, buf_post;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, rec_data;
	wire [7:0] rec_len, sense_asc, sense_ascq;
	wire [3:0] sense_key;
	wire [15:0] buf_len;
	int err_count = 0, total_checks = 0;
	always #50 aclk = ~aclk;
	event_reporter u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .buf_post(buf_post), .buf_len(buf_len), .evt_valid(evt_valid),
		.evt_ready(evt_ready), .evt_kind(evt_kind), .evt_burst(evt_burst), .evt_lun(evt_lun),
		.evt_reason(evt_reason), .rec_valid(rec_valid), .rec_ready(rec_ready),
		.rec_data(rec_data), .rec_last(rec_last), .rec_len(rec_len), .sense_key(sense_key),
		.sense_asc(sense_asc), .sense_ascq(sense_ascq), .irq(irq));
	driver_model u_drv (.aclk(aclk), .post_req(post_req), .post_len(post_len), .stall(stall),
		.buf_post(buf_post), .buf_len(buf_len), .rec_ready(rec_ready));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw, tr, ok;
		logic [31:0] got;
		logic [1:0] rsp;
		int n;
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
		end else begin
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
		end
		n = 0;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tr = arvalid & arready;
			ok = w ? bvalid : rvalid;
			rsp = w ? bresp : rresp;
			got = rdata;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tr) arvalid <= 1'h0;
			n++;
		end while (!ok && n < 50);
		bready <= 1'h0;
		rready <= 1'h0;
		@(posedge aclk);
		chk(rsp, er);
		if (!w) chk(got, d);
	endtask
	task automatic post(input logic [15:0] len);
		post_req <= 1'h1;
		post_len <= len;
		@(posedge aclk);
		post_req <= 1'h0;
		repeat (5) @(posedge aclk);
	endtask
	task automatic evt(input logic k, input logic b, input logic [31:0] r, input int m,
		output logic took);
		int n;
		evt_kind <= k;
		evt_burst <= b;
		evt_reason <= r;
		evt_valid <= 1'h1;
		n = 0;
		do begin
			@(negedge aclk);
			took = evt_ready;
			@(posedge aclk);
			n++;
		end while (!took && n < m);
		if (took) evt_valid <= 1'h0;
	endtask
	task automatic rec(input logic [31:0] code, input logic [31:0] rsn, input int nw);
		logic [31:0] w [4];
		int i, n;
		w = '{code, evt_lun[31:0], evt_lun[63:32], rsn};
		for (i = 0; i < nw; i++) begin
			n = 0;
			do begin
				@(negedge aclk);
				n++;
			end while (!(rec_valid && rec_ready) && n < 30);
			chk(rec_data, w[i]);
			chk(rec_last, i == nw - 1);
			chk(rec_len, nw * 4);
			@(posedge aclk);
		end
	endtask
	task automatic none;
		repeat (6) begin
			@(negedge aclk);
			chk(rec_valid, 1'h0);
		end
		@(posedge aclk);
	endtask
	task automatic irq_is(input logic e);
		@(negedge aclk);
		chk(irq, e);
		@(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		axi(1'h0, `REG_CTRL, 32'h6, `RESP_OKAY);
		axi(1'h0, `REG_EVT_SIZE, 32'h10, `RESP_OKAY);
		axi(1'h0, `REG_SUBSCRIBE, 32'h0, `RESP_OKAY);
		axi(1'h0, 8'h20, 32'h0, `RESP_SLVERR);
		axi(1'h1, `REG_STATE, 32'h1, `RESP_SLVERR);
		axi(1'h1, `REG_IRQ_MASK, 32'h7, `RESP_OKAY);
		axi(1'h0, `REG_IRQ_MASK, 32'h7, `RESP_OKAY);
		irq_is(1'h0);
		$display("regs done");
	endtask
	task automatic t_reset;
		logic [19:0] sense [3];
		int r;
		sense = '{20'h62900, 20'h63f0e, 20'h52500};
		axi(1'h1, `REG_CTRL, 32'h5, `RESP_OKAY);
		for (r = 0; r < 3; r++) begin
			stall <= (r == 1);
			post(16'h0010);
			evt(1'h0, 1'h0, r, 20, t);
			rec(32'h1, r, 4);
			chk({sense_key, sense_asc, sense_ascq}, sense[r]);
		end
		stall <= 1'h0;
		$display("reset done");
	endtask
	task automatic t_gate;
		axi(1'h1, `REG_CTRL, 32'h4, `RESP_OKAY);
		axi(1'h1, `REG_SUBSCRIBE, 32'h12, `RESP_OKAY);
		post(16'h0010);
		evt(1'h0, 1'h0, 32'h1, 20, t);
		none();
		evt(1'h0, 1'h0, 32'h2, 20, t);
		none();
		evt(1'h1, 1'h0, 32'h8, 20, t);
		none();
		evt(1'h1, 1'h0, 32'h16, 20, t);
		rec(32'h2, 32'h12, 4);
		$display("gate done");
	endtask
	task automatic t_drop;
		axi(1'h1, `REG_CTRL, 32'h2, `RESP_OKAY);
		axi(1'h1, `REG_IRQ_STATUS, 32'h7, `RESP_OKAY);
		irq_is(1'h0);
		evt(1'h0, 1'h0, 32'h0, 20, t);
		none();
		axi(1'h0, `REG_IRQ_STATUS, 32'h1, `RESP_OKAY);
		irq_is(1'h1);
		axi(1'h0, `REG_DROP_COUNT, 32'h1, `RESP_OKAY);
		fork
			post(16'h0010);
			rec(32'h80000000, 32'h0, 1);
		join
		axi(1'h0, `REG_SENSE, 32'h00052500, `RESP_OKAY);
		axi(1'h1, `REG_IRQ_STATUS, 32'h7, `RESP_OKAY);
		irq_is(1'h0);
		axi(1'h1, `REG_CTRL, 32'h0, `RESP_OKAY);
		evt(1'h0, 1'h0, 32'h0, 20, t);
		post(16'h0010);
		evt(1'h0, 1'h0, 32'h0, 20, t);
		rec(32'h80000001, 32'h0, 4);
		axi(1'h0, `REG_DROP_COUNT, 32'h2, `RESP_OKAY);
		$display("drop done");
	endtask
	task automatic t_short;
		axi(1'h1, `REG_IRQ_STATUS, 32'h7, `RESP_OKAY);
		fork
			post(16'h0008);
			rec(32'h0, 32'h0, 1);
		join
		axi(1'h0, `REG_IRQ_STATUS, 32'h6, `RESP_OKAY);
		irq_is(1'h1);
		$display("short done");
	endtask
	task automatic t_throttle;
		axi(1'h1, `REG_CTRL, 32'h4, `RESP_OKAY);
		evt(1'h0, 1'h1, 32'h0, 10, t);
		chk(t, 1'h0);
		fork
			post(16'h0010);
			evt(1'h0, 1'h1, 32'h0, 30, t);
			rec(32'h1, 32'h0, 4);
		join
		chk(t, 1'h1);
		$display("throttle done");
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_reset();
		t_gate();
		t_drop();
		t_short();
		t_throttle();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		err_count++;
		conclude();
	end
endmodule
bind event_reporter event_reporter_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last),
	.rec_len(rec_len), .sense_key(sense_key), .sense_asc(sense_asc), .sense_ascq(sense_ascq));

//--- event_reporter_checker.sv
// Assertion checker for the record stream and sense outputs of the event reporter.
module event_reporter_checker (
	input wire aclk,
	input wire aresetn,
	input wire rec_valid,
	input wire rec_ready,
	input wire [31:0] rec_data,
	input wire rec_last,
	input wire [7:0] rec_len,
	input wire [3:0] sense_key,
	input wire [7:0] sense_asc,
	input wire [7:0] sense_ascq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] word_ff;
	logic reset_rec_ff;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// Tracks the word position within a record and whether it is a reset record.
	always @(posedge aclk) begin
		if (!aresetn) begin
			word_ff <= 2'h0;
		end else if (rec_valid && rec_ready) begin
			word_ff <= rec_last ? 2'h0 : word_ff + 2'h1;
		end
	end
	always @(posedge aclk) begin
		if (rec_valid && rec_ready && word_ff == 2'h0) begin
			reset_rec_ff <= rec_data[30:0] == 31'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_rec_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
		else $error("record word changed while stalled");
	a_rec_len: assert property (rec_valid |-> rec_len == 8'h04 || rec_len == 8'h10)
		else $error("record length wrong");
	a_short_code: assert property (rec_valid && rec_len == 8'h04 |-> rec_last && rec_data[30:0] == 31'h0)
		else $error("short record wrong");
	a_full_code: assert property (rec_valid && rec_len == 8'h10 && word_ff == 2'h0 |->
		rec_data[30:0] == 31'h1 || rec_data[30:0] == 31'h2)
		else $error("record code wrong");
	a_last_word: assert property (rec_valid && rec_len == 8'h10 |-> rec_last == (word_ff == 2'h3))
		else $error("last word misplaced");
	a_reset_reason: assert property (rec_valid && word_ff == 2'h3 && reset_rec_ff |-> rec_data <= 32'h2)
		else $error("reset reason out of range");
	a_rec_gap: assert property (rec_valid && rec_ready && rec_last |=> !rec_valid)
		else $error("no idle after record");
	a_sense_gone: assert property (sense_asc == 8'h25 |-> sense_key == 4'h5 && sense_ascq == 8'h00)
		else $error("removal sense wrong");
	cover property (rec_valid && rec_ready && rec_last && rec_len == 8'h04);
	cover property (rec_valid && rec_ready && rec_last && rec_len == 8'h10);
	cover property (rec_valid && !rec_ready);
endmodule

//--- event_reporter_defines.vh
// Constants shared by the event queue reporter files.
`ifndef EVENT_REPORTER_DEFINES_VH
`define EVENT_REPORTER_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_EVT_SIZE 8'h04
`define REG_SUBSCRIBE 8'h08
`define REG_STATE 8'h0c
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_SENSE 8'h18
`define REG_DROP_COUNT 8'h1c

////////////////////////////////////////////////////////////////////////////////
// Control register fields and reset values.
`define CTRL_HOT_PLUG_FEATURE 0
`define CTRL_PROMPT_EN 1
`define CTRL_THROTTLE_EN 2
`define CTRL_RESET 3'h6
`define EVT_SIZE_RESET 16'h0010
`define SUBSCRIBE_RESET 32'h00000000

////////////////////////////////////////////////////////////////////////////////
// Interrupt status bits.
`define IRQ_W 3
`define IRQ_DROPPED 0
`define IRQ_SENT 1
`define IRQ_SHORT 2

////////////////////////////////////////////////////////////////////////////////
// Event record encodings.
`define CODE_NO_EVENT 32'h00000000
`define CODE_TRANSPORT_RESET 32'h00000001
`define ASYNC_NOTICE_CODE 32'h00000002
`define LOST_NOTICES_BIT 31
`define REASON_UNIT_RESET 32'h00000000
`define REASON_UNIT_APPEARED 32'h00000001
`define REASON_UNIT_GONE 32'h00000002
`define KIND_RESET 1'b0
`define KIND_ASYNC 1'b1
`define LEN_SHORT_RECORD 8'h04
`define LEN_FULL_RECORD 8'h10
`define WORDS_SHORT 2'h0
`define WORDS_FULL 2'h3

////////////////////////////////////////////////////////////////////////////////
// Sense data exposed for transport resets.
`define SENSE_ILLEGAL_REQUEST 4'h5
`define SENSE_UNIT_ATTENTION 4'h6
`define ASC_UNIT_GONE 8'h25
`define ASCQ_UNIT_GONE 8'h00
`define ASC_UNIT_RESET 8'h29
`define ASCQ_UNIT_RESET 8'h00
`define ASC_UNIT_APPEARED 8'h3f
`define ASCQ_UNIT_APPEARED 8'h0e

////////////////////////////////////////////////////////////////////////////////
// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
